/* File: rtl/pulse_reference_input_decoder.sv */
// module: pulse train reference decoder with position error counter and AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module pulse_reference_input_decoder #(
    parameter int COUNT_W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pulse_in_a,
    input wire logic pulse_in_b,
    input wire logic error_counter_clear_input,
    output logic [COUNT_W-1:0] position_error
);
    localparam int FW = pulse_ref_pkg::FILT_W;
    localparam int DW = pulse_ref_pkg::DIGIT_W;

    logic [15:0] pulse_input_form_switch_reg;
    logic [15:0] active_form_reg;
    logic servo_on_reg;
    logic alarm_reg;
    logic restart_pending_reg;
    logic restart_req;
    logic [3:0] pulse_form;
    logic [3:0] clear_form;
    logic [3:0] clear_op;
    logic [3:0] filter_sel;
    logic [FW-1:0] filt_len;
    logic a_lvl;
    logic b_lvl;
    logic clr_lvl;
    logic a_prev_reg;
    logic b_prev_reg;
    logic clr_prev_reg;
    logic alarm_prev_reg;
    logic clear_now;
    logic up;
    logic down;

    // ----------------------------------------------------------------
    // digit helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] digit(input logic [15:0] word, input int lsb);
        digit = word[lsb +: DW];
    endfunction

    function automatic logic form_ok(input logic [15:0] word);
        form_ok = digit(word, pulse_ref_pkg::PULSE_FORM_LSB) <=
                  digit(pulse_ref_pkg::FORM_SWITCH_MAX, pulse_ref_pkg::PULSE_FORM_LSB)
               && digit(word, pulse_ref_pkg::CLEAR_FORM_LSB) <=
                  digit(pulse_ref_pkg::FORM_SWITCH_MAX, pulse_ref_pkg::CLEAR_FORM_LSB)
               && digit(word, pulse_ref_pkg::CLEAR_OP_LSB) <=
                  digit(pulse_ref_pkg::FORM_SWITCH_MAX, pulse_ref_pkg::CLEAR_OP_LSB)
               && digit(word, pulse_ref_pkg::FILTER_SEL_LSB) <=
                  digit(pulse_ref_pkg::FORM_SWITCH_MAX, pulse_ref_pkg::FILTER_SEL_LSB);
    endfunction

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;

    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    logic wr_form;
    logic wr_ctrl;
    logic wr_legal;
    assign wr_form = wr_fire && aw_addr_reg == pulse_ref_pkg::FORM_SWITCH_OFFSET;
    assign wr_ctrl = wr_fire && aw_addr_reg == pulse_ref_pkg::CONTROL_OFFSET;
    assign wr_legal = form_ok({(w_strb_reg[1] ? w_data_reg[15:8]
                                             : pulse_input_form_switch_reg[15:8]),
                               (w_strb_reg[0] ? w_data_reg[7:0]
                                             : pulse_input_form_switch_reg[7:0])});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pulse_ref_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_ctrl || (wr_form && wr_legal)) ? pulse_ref_pkg::RESP_OKAY
                                                             : pulse_ref_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // setting register, out-of-range values refused
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_input_form_switch_reg <= pulse_ref_pkg::FORM_SWITCH_RESET;
        end else if (wr_form && wr_legal) begin
            if (w_strb_reg[0]) begin
                pulse_input_form_switch_reg[7:0] <= w_data_reg[7:0];
            end
            if (w_strb_reg[1]) begin
                pulse_input_form_switch_reg[15:8] <= w_data_reg[15:8];
            end
        end
    end

    // ----------------------------------------------------------------
    // control bits and restart
    // ----------------------------------------------------------------
    assign restart_req = wr_ctrl && w_strb_reg[0] && w_data_reg[pulse_ref_pkg::CTRL_RESTART_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            servo_on_reg <= 1'b0;
            alarm_reg <= 1'b0;
        end else if (wr_ctrl && w_strb_reg[0]) begin
            servo_on_reg <= w_data_reg[pulse_ref_pkg::CTRL_SERVO_ON_BIT];
            alarm_reg <= w_data_reg[pulse_ref_pkg::CTRL_ALARM_BIT];
        end
    end

    // new setting takes effect only at restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_form_reg <= pulse_ref_pkg::FORM_SWITCH_RESET;
        end else if (restart_req) begin
            active_form_reg <= pulse_input_form_switch_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            restart_pending_reg <= 1'b0;
        end else if (wr_form && wr_legal) begin
            restart_pending_reg <= 1'b1;
        end else if (restart_req) begin
            restart_pending_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= pulse_ref_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= pulse_ref_pkg::RESP_OKAY;
                case (s_axi_araddr)
                    pulse_ref_pkg::FORM_SWITCH_OFFSET:
                        s_axi_rdata <= {16'h0000, pulse_input_form_switch_reg};
                    pulse_ref_pkg::CONTROL_OFFSET:
                        s_axi_rdata <= {29'h00000000, alarm_reg, servo_on_reg, 1'b0};
                    pulse_ref_pkg::ACTIVE_FORM_OFFSET:
                        s_axi_rdata <= {16'h0000, active_form_reg};
                    pulse_ref_pkg::ERROR_COUNT_OFFSET:
                        s_axi_rdata <= 32'(position_error);
                    pulse_ref_pkg::STATUS_OFFSET:
                        s_axi_rdata <= {30'h00000000, restart_pending_reg, clear_now};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= pulse_ref_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // active field decode
    // ----------------------------------------------------------------
    assign pulse_form = digit(active_form_reg, pulse_ref_pkg::PULSE_FORM_LSB);
    assign clear_form = digit(active_form_reg, pulse_ref_pkg::CLEAR_FORM_LSB);
    assign clear_op = digit(active_form_reg, pulse_ref_pkg::CLEAR_OP_LSB);
    assign filter_sel = digit(active_form_reg, pulse_ref_pkg::FILTER_SEL_LSB);

    always_comb begin
        case (filter_sel)
            pulse_ref_pkg::FILT_LINE_1M: filt_len = pulse_ref_pkg::FILT_LEN_1M;
            pulse_ref_pkg::FILT_OPEN_COLL: filt_len = pulse_ref_pkg::FILT_LEN_OC;
            pulse_ref_pkg::FILT_LINE_4M: filt_len = pulse_ref_pkg::FILT_LEN_4M;
            default: filt_len = pulse_ref_pkg::FILT_LEN_1M;
        endcase
    end

    // ----------------------------------------------------------------
    // synchronised, filtered inputs
    // ----------------------------------------------------------------
    input_filter #(.WIDTH(FW)) filt_a (
        .aclk(aclk), .aresetn(aresetn), .pin(pulse_in_a), .length(filt_len), .level(a_lvl)
    );
    input_filter #(.WIDTH(FW)) filt_b (
        .aclk(aclk), .aresetn(aresetn), .pin(pulse_in_b), .length(filt_len), .level(b_lvl)
    );
    input_filter #(.WIDTH(FW)) filt_clr (
        .aclk(aclk), .aresetn(aresetn), .pin(error_counter_clear_input), .length(filt_len),
        .level(clr_lvl)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_prev_reg <= 1'b0;
            b_prev_reg <= 1'b0;
            clr_prev_reg <= 1'b0;
            alarm_prev_reg <= 1'b0;
        end else begin
            a_prev_reg <= a_lvl;
            b_prev_reg <= b_lvl;
            clr_prev_reg <= clr_lvl;
            alarm_prev_reg <= alarm_reg;
        end
    end

    // ----------------------------------------------------------------
    // pulse form decode
    // ----------------------------------------------------------------
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic a_edge;
    logic b_edge;
    assign a_rise = a_lvl && !a_prev_reg;
    assign a_fall = !a_lvl && a_prev_reg;
    assign b_rise = b_lvl && !b_prev_reg;
    assign b_fall = !b_lvl && b_prev_reg;
    assign a_edge = a_rise || a_fall;
    assign b_edge = b_rise || b_fall;

    always_comb begin
        up = 1'b0;
        down = 1'b0;
        case (pulse_form)
            pulse_ref_pkg::FORM_SIGN_POS: begin
                up = a_rise && !b_lvl;
                down = a_rise && b_lvl;
            end
            pulse_ref_pkg::FORM_SIGN_NEG: begin
                up = a_fall && b_lvl;
                down = a_fall && !b_lvl;
            end
            pulse_ref_pkg::FORM_CWCCW_POS: begin
                up = a_rise && !b_rise;
                down = b_rise && !a_rise;
            end
            pulse_ref_pkg::FORM_CWCCW_NEG: begin
                up = a_fall && !b_fall;
                down = b_fall && !a_fall;
            end
            pulse_ref_pkg::FORM_QUAD_X1: begin
                up = a_rise && !b_lvl;
                down = a_fall && !b_lvl;
            end
            pulse_ref_pkg::FORM_QUAD_X2: begin
                up = a_edge && (a_lvl != b_lvl);
                down = a_edge && (a_lvl == b_lvl);
            end
            pulse_ref_pkg::FORM_QUAD_X4: begin
                up = (a_edge && !b_edge && (a_lvl != b_lvl))
                  || (b_edge && !a_edge && (a_lvl == b_lvl));
                down = (a_edge && !b_edge && (a_lvl == b_lvl))
                    || (b_edge && !a_edge && (a_lvl != b_lvl));
            end
            default: begin
                up = 1'b0;
                down = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // clear sources
    // ----------------------------------------------------------------
    logic clr_by_input;
    logic clr_by_op;

    always_comb begin
        case (clear_form)
            pulse_ref_pkg::CLR_HIGH_LEVEL: clr_by_input = clr_lvl;
            pulse_ref_pkg::CLR_RISING: clr_by_input = clr_lvl && !clr_prev_reg;
            pulse_ref_pkg::CLR_LOW_LEVEL: clr_by_input = !clr_lvl;
            pulse_ref_pkg::CLR_FALLING: clr_by_input = !clr_lvl && clr_prev_reg;
            default: clr_by_input = 1'b0;
        endcase
    end

    always_comb begin
        case (clear_op)
            pulse_ref_pkg::OP_BASEBLOCK: clr_by_op = !servo_on_reg || alarm_reg;
            pulse_ref_pkg::OP_NEVER: clr_by_op = 1'b0;
            pulse_ref_pkg::OP_ALARM: clr_by_op = alarm_reg && !alarm_prev_reg;
            default: clr_by_op = 1'b0;
        endcase
    end

    assign clear_now = clr_by_input || clr_by_op;

    // ----------------------------------------------------------------
    // position error counter
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            position_error <= '0;
        end else if (clear_now) begin
            position_error <= '0;
        end else if (up) begin
            position_error <= position_error + 1'b1;
        end else if (down) begin
            position_error <= position_error - 1'b1;
        end
    end
endmodule // pulse_reference_input_decoder

/* File: rtl/pulse_ref_pkg.sv */
// package: register map, field layout and timing for the pulse reference decoder
package pulse_ref_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] FORM_SWITCH_OFFSET = 8'h00;
    localparam logic [7:0] CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] ACTIVE_FORM_OFFSET = 8'h08;
    localparam logic [7:0] ERROR_COUNT_OFFSET = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    // ----------------------------------------------------------------
    // field layout of the form switch
    // ----------------------------------------------------------------
    localparam int PULSE_FORM_LSB = 0;
    localparam int CLEAR_FORM_LSB = 4;
    localparam int CLEAR_OP_LSB = 8;
    localparam int FILTER_SEL_LSB = 12;
    localparam int DIGIT_W = 4;
    localparam logic [15:0] FORM_SWITCH_RESET = 16'h0000;
    localparam logic [15:0] FORM_SWITCH_MAX = 16'h2236;
    // ----------------------------------------------------------------
    // control register bits
    // ----------------------------------------------------------------
    localparam int CTRL_RESTART_BIT = 0;
    localparam int CTRL_SERVO_ON_BIT = 1;
    localparam int CTRL_ALARM_BIT = 2;
    // ----------------------------------------------------------------
    // status register bits
    // ----------------------------------------------------------------
    localparam int STAT_CLEARING_BIT = 0;
    localparam int STAT_PENDING_BIT = 1;
    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] FORM_SIGN_POS = 4'h0;
    localparam logic [3:0] FORM_CWCCW_POS = 4'h1;
    localparam logic [3:0] FORM_QUAD_X1 = 4'h2;
    localparam logic [3:0] FORM_QUAD_X2 = 4'h3;
    localparam logic [3:0] FORM_QUAD_X4 = 4'h4;
    localparam logic [3:0] FORM_SIGN_NEG = 4'h5;
    localparam logic [3:0] FORM_CWCCW_NEG = 4'h6;
    localparam logic [3:0] CLR_HIGH_LEVEL = 4'h0;
    localparam logic [3:0] CLR_RISING = 4'h1;
    localparam logic [3:0] CLR_LOW_LEVEL = 4'h2;
    localparam logic [3:0] CLR_FALLING = 4'h3;
    localparam logic [3:0] OP_BASEBLOCK = 4'h0;
    localparam logic [3:0] OP_NEVER = 4'h1;
    localparam logic [3:0] OP_ALARM = 4'h2;
    localparam logic [3:0] FILT_LINE_1M = 4'h0;
    localparam logic [3:0] FILT_OPEN_COLL = 4'h1;
    localparam logic [3:0] FILT_LINE_4M = 4'h2;
    // ----------------------------------------------------------------
    // filter timing: least pulse half-period accepted per rate
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int HALF_LINE_1M_NS = 500;
    localparam int HALF_OPEN_COLL_NS = 2500;
    localparam int HALF_LINE_4M_NS = 125;
    localparam int FILT_MARGIN_DIV = 2;
    localparam int FILT_W = 8;
    localparam logic [FILT_W-1:0] FILT_LEN_1M =
        FILT_W'(HALF_LINE_1M_NS * CLK_MHZ / 1000 / FILT_MARGIN_DIV);
    localparam logic [FILT_W-1:0] FILT_LEN_OC =
        FILT_W'(HALF_OPEN_COLL_NS * CLK_MHZ / 1000 / FILT_MARGIN_DIV);
    localparam logic [FILT_W-1:0] FILT_LEN_4M =
        FILT_W'(HALF_LINE_4M_NS * CLK_MHZ / 1000 / FILT_MARGIN_DIV);
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: rtl/input_filter.sv */
// module: pin synchroniser with programmable glitch filter
`timescale 1ns/1ns
module input_filter #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    input wire logic [WIDTH-1:0] length,
    output logic level
);
    logic sync1_reg;
    logic sync2_reg;
    logic [WIDTH-1:0] count_reg;

    // ----------------------------------------------------------------
    // two-stage synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
        end
    end

    // ----------------------------------------------------------------
    // accept a new level once it has held for length + 1 cycles
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= '0;
            level <= 1'b0;
        end else if (sync2_reg == level) begin
            count_reg <= '0;
        end else if (count_reg >= length) begin
            count_reg <= '0;
            level <= sync2_reg;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end
endmodule // input_filter

/* File: verif/pulse_ref_checker.sv */
// checker: bus and counter assertions for the pulse reference decoder
`timescale 1ns/1ns
module pulse_ref_checker #(
    parameter int COUNT_W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [COUNT_W-1:0] position_error
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    aw_ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
        |=> s_axi_rresp == pulse_ref_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    read_only_write_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_awaddr inside {8'h08, 8'h0C, 8'h10}
        |-> ##[1:3] s_axi_bvalid && s_axi_bresp == pulse_ref_pkg::RESP_SLVERR)
        else $error("read only write not refused");
    reset_counter_a: assert property ($rose(aresetn)
        |-> position_error == '0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not cleared by reset");
    count_step_a: assert property ($changed(position_error) |-> position_error == '0
        || position_error - $past(position_error) == COUNT_W'(1)
        || $past(position_error) - position_error == COUNT_W'(1))
        else $error("counter moved by more than one");
endmodule // pulse_ref_checker
bind pulse_reference_input_decoder pulse_ref_checker #(.COUNT_W(COUNT_W)) chk (.*);

/* File: verif/pulse_host_model.sv */
// partner: host controller driving the reference pulse pins
`timescale 1ns/1ns
module pulse_host_model (
    input wire logic aclk,
    output logic pulse_a,
    output logic pulse_b
);
    int hold = 20;
    logic inv = 1'b0;
    initial begin
        pulse_a = 1'b0;
        pulse_b = 1'b0;
    end
    task automatic ph(input logic x, input logic y);
        @(posedge aclk);
        pulse_a <= x ^ inv;
        pulse_b <= y ^ inv;
        repeat (hold) @(posedge aclk);
    endtask
    task automatic idle(input logic [3:0] f);
        inv = (f == 4'h5 || f == 4'h6);
        ph(1'b0, 1'b0);
    endtask
    task automatic step(input logic [3:0] f, input logic d);
        case (f)
            4'h0, 4'h5: begin ph(1'b0, d); ph(1'b1, d); ph(1'b0, d); end
            4'h1, 4'h6: begin ph(d, !d); ph(1'b0, 1'b0); end
            default: if (d) begin ph(1'b1, 1'b0); ph(1'b1, 1'b1); ph(1'b0, 1'b1); ph(1'b0, 1'b0); end
            else begin ph(1'b0, 1'b1); ph(1'b1, 1'b1); ph(1'b1, 1'b0); ph(1'b0, 1'b0); end
        endcase
    endtask
endmodule // pulse_host_model

/* File: verif/pulse_reference_input_decoder_test.sv */
// testbench: registers, pulse forms, clear modes and filters of the decoder
`timescale 1ns/1ns
module pulse_reference_input_decoder_test;
    logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, error_counter_clear_input = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic pulse_in_a, pulse_in_b;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, position_error, d, base, v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int errors = 0, tests_run = 0, seed = 32'h2C5C, n;
    int lens[3] = '{25, 125, 6};
    localparam logic [31:0] ERR = 32'(pulse_ref_pkg::RESP_SLVERR);
    always #5 aclk = ~aclk;
    pulse_reference_input_decoder uut (.*);
    pulse_host_model host (.aclk(aclk), .pulse_a(pulse_in_a), .pulse_b(pulse_in_b));
    task automatic report_and_stop;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bound(input int k);
        if (k >= 50) begin
            errors++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        int k = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && k < 50);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        bound(k);
    endtask
    task automatic rd(input logic [7:0] a);
        int k = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && k < 50);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        bound(k);
    endtask
    task automatic cfg(input logic [31:0] c, input logic [31:0] ctl);
        wr(8'h00, c);
        wr(8'h04, ctl);
    endtask
    function automatic logic [31:0] mag(input logic [31:0] x);
        return x[31] ? -x : x;
    endfunction
    function automatic logic [3:0] rnd(input int m);
        return 4'($unsigned($random(seed)) % m);
    endfunction
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00);
        chk("switch reset", 32'h0, d);
        wr(8'h00, 32'h2237);
        chk("over range resp", ERR, r);
        rd(8'h00);
        chk("over range kept", 32'h0, d);
        wr(8'h00, 32'h2236);
        rd(8'h08);
        chk("active before restart", 32'h0, d);
        wr(8'h04, 32'h1);
        rd(8'h08);
        chk("active after restart", 32'h2236, d);
        wr(8'h08, 32'h0);
        chk("read only resp", ERR, r);
        rd(8'h20);
        chk("unmapped data", 32'h0, d);
        chk("unmapped resp", ERR, r);
        repeat (4) begin
            v = {16'h0, rnd(3), rnd(3), rnd(4), rnd(7)};
            wr(8'h00, v);
            rd(8'h00);
            chk("switch readback", v, d);
        end
        for (int f = 0; f < 7; f++) begin
            cfg(32'h2000 | f, 32'h1);
            host.idle(4'(f));
            chk("servo off count", 32'h0, position_error);
            wr(8'h04, 32'h2);
            n = 1 + rnd(4);
            repeat (n) host.step(4'(f), 1'b1);
            chk("forward count", n * (f == 3 ? 2 : f == 4 ? 4 : 1), mag(position_error));
            repeat (n) host.step(4'(f), 1'b0);
            chk("return count", 32'h0, position_error);
        end
        for (int c = 0; c < 4; c++) begin
            error_counter_clear_input <= c[1];
            cfg(32'h2100 | (c << 4), 32'h3);
            host.idle(4'h0);
            base = position_error;
            repeat (2) host.step(4'h0, 1'b1);
            chk("no auto clear", 32'h2, mag(position_error - base));
            error_counter_clear_input <= !c[1];
            repeat (20) @(posedge aclk);
            chk("clear input", 32'h0, position_error);
            host.step(4'h0, 1'b1);
            chk("count under clear", c[0], mag(position_error));
            error_counter_clear_input <= c[1];
            repeat (20) @(posedge aclk);
            chk("release clear", c[0], mag(position_error));
        end
        wr(8'h04, 32'h6);
        repeat (3) @(posedge aclk);
        chk("alarm op never", 32'h1, mag(position_error));
        error_counter_clear_input <= 1'b0;
        cfg(32'h2200, 32'h3);
        base = position_error;
        repeat (2) host.step(4'h0, 1'b1);
        wr(8'h04, 32'h0);
        repeat (3) @(posedge aclk);
        chk("servo off op alarm", 32'h2, mag(position_error - base));
        wr(8'h04, 32'h4);
        repeat (3) @(posedge aclk);
        chk("alarm clear", 32'h0, position_error);
        rd(8'h0C);
        chk("count reg", 32'h0, d);
        for (int f = 0; f < 3; f++) begin
            cfg(f << 12, 32'h3);
            host.hold = lens[f] + 20;
            host.idle(4'h0);
            base = position_error;
            host.hold = lens[f] / 2;
            host.step(4'h0, 1'b1);
            host.hold = lens[f] + 20;
            host.step(4'h0, 1'b1);
            chk("filtered pulse", 32'h1, mag(position_error - base));
        end
        report_and_stop();
    end
endmodule // pulse_reference_input_decoder_test
